// ---- design/la_pkg.sv ----
// Shared constants and types for the logic analyzer trigger front end.
package la_pkg;
    // Register word indices on the Avalon-MM word address.
    localparam logic [5:0] LA_ADDR_CTRL = 6'h00;
    localparam logic [5:0] LA_ADDR_STATUS = 6'h01;
    localparam logic [5:0] LA_ADDR_INT_STAT = 6'h02;
    localparam logic [5:0] LA_ADDR_INT_EN = 6'h03;
    localparam logic [5:0] LA_ADDR_INT_CLR = 6'h04;
    localparam logic [5:0] LA_ADDR_CNT0 = 6'h05;
    localparam logic [5:0] LA_ADDR_CNT1 = 6'h06;
    localparam logic [5:0] LA_ADDR_PAT0 = 6'h10;
    localparam logic [5:0] LA_ADDR_PAT1 = 6'h20;
    localparam int LA_ADDR_W = 6;
    localparam int LA_PAT_SPAN = 16;

    // Control register fields.
    localparam int LA_CTRL_RUN = 0;
    localparam int LA_CTRL_TIN_POL = 1;
    localparam int LA_CTRL_TOUT_POL = 2;
    localparam int LA_CTRL_TIN_AND = 3;
    localparam int LA_CTRL_COND = 4;
    localparam int LA_CTRL_CMP0 = 8;
    localparam int LA_CTRL_CMP1 = 12;
    localparam logic [31:0] LA_CTRL_MASK = 32'h0000_777f;
    localparam logic [31:0] LA_CTRL_RST = 32'h0000_0000;

    // Status and interrupt bit positions.
    localparam int LA_ST_EV0 = 0;
    localparam int LA_ST_EV1 = 1;
    localparam int LA_ST_TRIG = 2;
    localparam int LA_ST_ARMED = 3;
    localparam int LA_ST_TIN = 4;
    localparam int LA_INT_W = 3;

    // Per-line pattern codes, eight lines to a word, four bits apart.
    localparam int LA_CODE_W = 3;
    localparam int LA_CODE_STRIDE = 4;
    localparam int LA_CODES_PER_WORD = 8;
    localparam logic [2:0] LA_CODE_ZERO = 3'h0;
    localparam logic [2:0] LA_CODE_ONE = 3'h1;
    localparam logic [2:0] LA_CODE_DC = 3'h2;
    localparam logic [2:0] LA_CODE_RISE = 3'h3;
    localparam logic [2:0] LA_CODE_FALL = 3'h4;
    localparam logic [2:0] LA_CODE_BOTH = 3'h5;
    localparam logic [31:0] LA_PAT_RST = 32'h2222_2222;

    // Pattern comparison modes.
    localparam logic [2:0] LA_CMP_EQ = 3'h0;
    localparam logic [2:0] LA_CMP_NE = 3'h1;
    localparam logic [2:0] LA_CMP_GT = 3'h2;
    localparam logic [2:0] LA_CMP_GE = 3'h3;
    localparam logic [2:0] LA_CMP_LT = 3'h4;
    localparam logic [2:0] LA_CMP_LE = 3'h5;

    // Trigger condition selections.
    localparam logic [2:0] LA_COND_EV0 = 3'h0;
    localparam logic [2:0] LA_COND_EV1 = 3'h1;
    localparam logic [2:0] LA_COND_AND = 3'h2;
    localparam logic [2:0] LA_COND_OR = 3'h3;
    localparam logic [2:0] LA_COND_SEQ = 3'h4;
    localparam logic [2:0] LA_COND_TIN = 3'h5;

    // Event counter limit width and reset value.
    localparam int LA_CNT_REG_W = 16;
    localparam logic [15:0] LA_CNT_RST = 16'h0001;

    // Build options for the trigger input and output.
    localparam int LA_TIN_NONE = 0;
    localparam int LA_TIN_PIN = 1;
    localparam int LA_TOUT_NONE = 0;
    localparam int LA_TOUT_PIN = 1;
    localparam int LA_TOUT_CHAIN = 2;

    typedef enum logic [2:0] {
        LA_IDLE = 3'b001,
        LA_ARMED = 3'b010,
        LA_FIRED = 3'b100
    } la_state_t;
endpackage

// ---- design/la_match.sv ----
// Per-line pattern matcher with equality and optional magnitude compare.
`timescale 1ns/1ps
module la_match import la_pkg::*; #(
    parameter int EDGE_N = 8,
    parameter int LEVEL_N = 8,
    parameter int MAG_EN = 1
) (
    input wire logic [EDGE_N+LEVEL_N-1:0] bus,
    input wire logic [EDGE_N+LEVEL_N-1:0] prev,
    input wire logic [(EDGE_N+LEVEL_N)*LA_CODE_W-1:0] codes,
    input wire logic [2:0] cmp,
    output logic match
);
    localparam int TW = EDGE_N + LEVEL_N;
    logic [TW-1:0] hit;
    logic [TW-1:0] val;
    logic eq;

    genvar i;
    generate
        for (i = 0; i < TW; i++) begin : g_line
            logic [2:0] c;
            assign c = codes[i*LA_CODE_W +: LA_CODE_W];
            assign val[i] = (c == LA_CODE_ONE);
            if (i < EDGE_N) begin : g_edge
                always_comb begin
                    unique case (c)
                        LA_CODE_ZERO: hit[i] = ~bus[i];
                        LA_CODE_ONE: hit[i] = bus[i];
                        LA_CODE_RISE: hit[i] = bus[i] & ~prev[i];
                        LA_CODE_FALL: hit[i] = ~bus[i] & prev[i];
                        LA_CODE_BOTH: hit[i] = bus[i] ^ prev[i];
                        default: hit[i] = 1'b1;
                    endcase
                end
            end else begin : g_level
                // Edge codes on a level line act as don't-care.
                always_comb begin
                    unique case (c)
                        LA_CODE_ZERO: hit[i] = ~bus[i];
                        LA_CODE_ONE: hit[i] = bus[i];
                        default: hit[i] = 1'b1;
                    endcase
                end
            end
        end
    endgenerate

    assign eq = &hit;

    always_comb begin
        match = eq;
        if (cmp == LA_CMP_NE) begin
            match = ~eq;
        end else if (MAG_EN != 0) begin
            unique case (cmp)
                LA_CMP_GT: match = bus > val;
                LA_CMP_GE: match = bus >= val;
                LA_CMP_LT: match = bus < val;
                LA_CMP_LE: match = bus <= val;
                default: match = eq;
            endcase
        end
    end
endmodule

// ---- design/la_evcnt.sv ----
// Event occurrence counter that flags an event after N pattern matches.
`timescale 1ns/1ps
module la_evcnt import la_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic hit,
    input wire logic [LA_CNT_REG_W-1:0] limit,
    output logic done
);
    localparam int CW = (CNT_W > 0) ? CNT_W : 1;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_done;
    logic [CW:0] inc;
    logic [CW-1:0] lim;

    assign lim = (limit[CW-1:0] == '0) ? CW'(1) : limit[CW-1:0];
    assign inc = {1'b0, count} + {{CW{1'b0}}, 1'b1};

    always_comb begin
        next_count = count;
        next_done = done;
        if (clr) begin
            next_count = '0;
            next_done = 1'b0;
        end else if (hit && !done) begin
            if (CNT_W == 0) begin
                next_done = 1'b1;
            end else begin
                next_count = inc[CW-1:0];
                if (inc >= {1'b0, lim}) begin
                    next_done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            done <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule

// ---- design/la_trigger.sv ----
// Trigger front end of the embedded logic analyzer with Avalon-MM registers.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module la_trigger import la_pkg::*; #(
    parameter int EDGE_N = 8,
    parameter int LEVEL_N = 8,
    parameter int CNT_W = 16,
    parameter int MAG_EN = 1,
    parameter int TIN_MODE = LA_TIN_PIN,
    parameter int TOUT_MODE = LA_TOUT_PIN
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [EDGE_N+LEVEL_N-1:0] TRIG_BUS,
    input wire logic TRIG_IN,
    output logic TRIG_PIN,
    output logic TRIG_CHAIN,
    output logic IRQ,
    input wire logic [LA_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    // Edge lines occupy the low bits, level lines the bits above them.
    localparam int TW = EDGE_N + LEVEL_N;
    localparam int PW = (TW + LA_CODES_PER_WORD - 1) / LA_CODES_PER_WORD;

    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [LA_CNT_REG_W-1:0] cnt0;
    logic [LA_CNT_REG_W-1:0] next_cnt0;
    logic [LA_CNT_REG_W-1:0] cnt1;
    logic [LA_CNT_REG_W-1:0] next_cnt1;
    logic [LA_INT_W-1:0] int_en;
    logic [LA_INT_W-1:0] next_int_en;
    logic [LA_INT_W-1:0] int_stat;
    logic [LA_INT_W-1:0] next_int_stat;
    logic [31:0] pat0 [PW];
    logic [31:0] next_pat0 [PW];
    logic [31:0] pat1 [PW];
    logic [31:0] next_pat1 [PW];
    logic [31:0] rd_mux;
    logic [31:0] next_rdata;
    logic next_waitreq;
    logic wr_go;
    logic [LA_INT_W-1:0] clr_bits;

    logic [TW-1:0] bus_prev;
    logic [TW*LA_CODE_W-1:0] codes0;
    logic [TW*LA_CODE_W-1:0] codes1;
    logic match0;
    logic match1;
    logic pattern_event_zero;
    logic pattern_event_one;
    la_state_t state;
    la_state_t next_state;
    logic run;
    logic tin_act;
    logic cond;
    logic trig_lvl;
    logic next_pin;
    logic next_chain;
    logic next_irq;
    logic [LA_INT_W-1:0] ev_set;
    logic [LA_INT_W-1:0] ev_now;
    logic [LA_INT_W-1:0] ev_last;

    function automatic logic [31:0] la_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pattern code fields are unpacked per line into flat vectors.
    genvar i;
    generate
        for (i = 0; i < TW; i++) begin : g_codes
            assign codes0[i*LA_CODE_W +: LA_CODE_W] =
                pat0[i / LA_CODES_PER_WORD]
                    [(i % LA_CODES_PER_WORD) * LA_CODE_STRIDE +: LA_CODE_W];
            assign codes1[i*LA_CODE_W +: LA_CODE_W] =
                pat1[i / LA_CODES_PER_WORD]
                    [(i % LA_CODES_PER_WORD) * LA_CODE_STRIDE +: LA_CODE_W];
        end
    endgenerate

    la_match #(
        .EDGE_N(EDGE_N),
        .LEVEL_N(LEVEL_N),
        .MAG_EN(MAG_EN)
    ) u_match0 (
        .bus(TRIG_BUS),
        .prev(bus_prev),
        .codes(codes0),
        .cmp(ctrl[LA_CTRL_CMP0 +: 3]),
        .match(match0)
    );

    la_match #(
        .EDGE_N(EDGE_N),
        .LEVEL_N(LEVEL_N),
        .MAG_EN(MAG_EN)
    ) u_match1 (
        .bus(TRIG_BUS),
        .prev(bus_prev),
        .codes(codes1),
        .cmp(ctrl[LA_CTRL_CMP1 +: 3]),
        .match(match1)
    );

    // In sequence mode the first event only counts once the second is seen.
    la_evcnt #(
        .CNT_W(CNT_W)
    ) u_cnt0 (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(state == LA_IDLE),
        .hit(match0 && state == LA_ARMED &&
             (ctrl[LA_CTRL_COND +: 3] != LA_COND_SEQ || pattern_event_one)),
        .limit(cnt0),
        .done(pattern_event_zero)
    );

    la_evcnt #(
        .CNT_W(CNT_W)
    ) u_cnt1 (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(state == LA_IDLE),
        .hit(match1 && state == LA_ARMED),
        .limit(cnt1),
        .done(pattern_event_one)
    );

    // Register bus: one wait state, request taken when waitrequest is low.
    assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;
    assign clr_bits = (wr_go && AVS_ADDRESS == LA_ADDR_INT_CLR) ?
                      AVS_WRITEDATA[LA_INT_W-1:0] : '0;

    always_comb begin
        rd_mux = '0;
        unique case (AVS_ADDRESS)
            LA_ADDR_CTRL: rd_mux = ctrl;
            LA_ADDR_STATUS: begin
                rd_mux[LA_ST_EV0] = pattern_event_zero;
                rd_mux[LA_ST_EV1] = pattern_event_one;
                rd_mux[LA_ST_TRIG] = (state == LA_FIRED);
                rd_mux[LA_ST_ARMED] = (state == LA_ARMED);
                rd_mux[LA_ST_TIN] = tin_act;
            end
            LA_ADDR_INT_STAT: rd_mux[LA_INT_W-1:0] = int_stat;
            LA_ADDR_INT_EN: rd_mux[LA_INT_W-1:0] = int_en;
            LA_ADDR_CNT0: rd_mux[LA_CNT_REG_W-1:0] = cnt0;
            LA_ADDR_CNT1: rd_mux[LA_CNT_REG_W-1:0] = cnt1;
            default: begin
                for (int w = 0; w < PW; w++) begin
                    if (AVS_ADDRESS == LA_ADDR_PAT0 + LA_ADDR_W'(w)) begin
                        rd_mux = pat0[w];
                    end
                    if (AVS_ADDRESS == LA_ADDR_PAT1 + LA_ADDR_W'(w)) begin
                        rd_mux = pat1[w];
                    end
                end
            end
        endcase
    end

    always_comb begin
        next_waitreq = AVS_WAITREQUEST ? !(AVS_READ || AVS_WRITE) : 1'b1;
        next_rdata = (AVS_WAITREQUEST && AVS_READ) ? rd_mux : AVS_READDATA;
        next_ctrl = ctrl;
        next_cnt0 = cnt0;
        next_cnt1 = cnt1;
        next_int_en = int_en;
        next_pat0 = pat0;
        next_pat1 = pat1;
        if (wr_go) begin
            unique case (AVS_ADDRESS)
                LA_ADDR_CTRL:
                    next_ctrl = la_merge(ctrl, AVS_WRITEDATA, AVS_BYTEENABLE)
                                & LA_CTRL_MASK;
                LA_ADDR_CNT0:
                    next_cnt0 = LA_CNT_REG_W'(
                        la_merge({16'h0000, cnt0}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE));
                LA_ADDR_CNT1:
                    next_cnt1 = LA_CNT_REG_W'(
                        la_merge({16'h0000, cnt1}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE));
                LA_ADDR_INT_EN:
                    if (AVS_BYTEENABLE[0]) begin
                        next_int_en = AVS_WRITEDATA[LA_INT_W-1:0];
                    end
                default: begin
                    for (int w = 0; w < PW; w++) begin
                        if (AVS_ADDRESS == LA_ADDR_PAT0 + LA_ADDR_W'(w)) begin
                            next_pat0[w] = la_merge(pat0[w], AVS_WRITEDATA,
                                                    AVS_BYTEENABLE);
                        end
                        if (AVS_ADDRESS == LA_ADDR_PAT1 + LA_ADDR_W'(w)) begin
                            next_pat1[w] = la_merge(pat1[w], AVS_WRITEDATA,
                                                    AVS_BYTEENABLE);
                        end
                    end
                end
            endcase
        end
    end

    // Trigger input qualification and condition selection.
    assign run = ctrl[LA_CTRL_RUN];
    always_comb begin
        tin_act = 1'b0;
        if (TIN_MODE == LA_TIN_PIN) begin
            tin_act = ctrl[LA_CTRL_TIN_POL] ? TRIG_IN : !TRIG_IN;
        end
        unique case (ctrl[LA_CTRL_COND +: 3])
            LA_COND_EV0: cond = pattern_event_zero;
            LA_COND_EV1: cond = pattern_event_one;
            LA_COND_AND: cond = pattern_event_zero && pattern_event_one;
            LA_COND_OR: cond = pattern_event_zero || pattern_event_one;
            LA_COND_SEQ: cond = pattern_event_zero && pattern_event_one;
            LA_COND_TIN: cond = tin_act;
            default: cond = 1'b0;
        endcase
        if (TIN_MODE == LA_TIN_NONE) begin
            if (ctrl[LA_CTRL_COND +: 3] == LA_COND_TIN) begin
                cond = 1'b0;
            end
        end else if (ctrl[LA_CTRL_TIN_AND]) begin
            cond = cond && tin_act;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            LA_IDLE: if (run) next_state = LA_ARMED;
            LA_ARMED: if (!run) next_state = LA_IDLE;
                      else if (cond) next_state = LA_FIRED;
            LA_FIRED: if (!run) next_state = LA_IDLE;
        endcase
    end

    // Output stage, registered from the next state.
    always_comb begin
        trig_lvl = ctrl[LA_CTRL_TOUT_POL] ? (next_state == LA_FIRED)
                                          : (next_state != LA_FIRED);
        next_pin = 1'b0;
        next_chain = 1'b0;
        if (TOUT_MODE == LA_TOUT_PIN) begin
            next_pin = trig_lvl;
        end
        if (TOUT_MODE == LA_TOUT_CHAIN) begin
            next_chain = trig_lvl;
        end
        ev_now = {next_state == LA_FIRED, pattern_event_one,
                  pattern_event_zero};
        ev_set = ev_now & ~ev_last;
        next_int_stat = (int_stat & ~clr_bits) | ev_set;
        next_irq = |(next_int_stat & next_int_en);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= '0;
            ctrl <= LA_CTRL_RST;
            cnt0 <= LA_CNT_RST;
            cnt1 <= LA_CNT_RST;
            int_en <= '0;
            int_stat <= '0;
            ev_last <= '0;
            IRQ <= 1'b0;
            bus_prev <= '0;
            state <= LA_IDLE;
            TRIG_PIN <= 1'b0;
            TRIG_CHAIN <= 1'b0;
            for (int w = 0; w < PW; w++) begin
                pat0[w] <= LA_PAT_RST;
                pat1[w] <= LA_PAT_RST;
            end
        end else if (CE) begin
            AVS_WAITREQUEST <= next_waitreq;
            AVS_READDATA <= next_rdata;
            ctrl <= next_ctrl;
            cnt0 <= next_cnt0;
            cnt1 <= next_cnt1;
            int_en <= next_int_en;
            int_stat <= next_int_stat;
            ev_last <= ev_now;
            IRQ <= next_irq;
            bus_prev <= TRIG_BUS;
            state <= next_state;
            TRIG_PIN <= next_pin;
            TRIG_CHAIN <= next_chain;
            pat0 <= next_pat0;
            pat1 <= next_pat1;
        end
    end
endmodule

// ---- dv/la_user_model.sv ----
// Behavioural model of the user logic that drives the watched bus.
`timescale 1ns/1ps
module la_user_model #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] want,
    output logic [WIDTH-1:0] bus
);
    // User logic launches its lines from flops on the sampling clock.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus <= '0;
        end else begin
            bus <= want;
        end
    end
endmodule

// ---- dv/la_trigger_monitor.sv ----
// Port-level assertions for the trigger front end.
`timescale 1ns/1ps
module la_trigger_monitor import la_pkg::*; #(
    parameter int EDGE_N = 8,
    parameter int LEVEL_N = 8,
    parameter int TOUT_MODE = LA_TOUT_PIN
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [EDGE_N+LEVEL_N-1:0] TRIG_BUS,
    input wire logic TRIG_IN,
    input wire logic TRIG_PIN,
    input wire logic TRIG_CHAIN,
    input wire logic IRQ,
    input wire logic [LA_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST
);
    default clocking mcb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    wait_answer_a: assert property ($rose(AVS_READ || AVS_WRITE) && CE
        |=> !AVS_WAITREQUEST) else $error("request left unanswered");
    wait_one_a: assert property (!AVS_WAITREQUEST && CE
        |=> AVS_WAITREQUEST) else $error("waitrequest low too long");
    wait_cause_a: assert property (!AVS_WAITREQUEST
        |-> $past(AVS_READ || AVS_WRITE)) else $error("answer without request");
    rdata_cause_a: assert property ($changed(AVS_READDATA)
        |-> $past(AVS_READ)) else $error("read data moved without a read");
    chain_quiet_a: assert property (TOUT_MODE == LA_TOUT_PIN
        |-> TRIG_CHAIN == 1'b0) else $error("chain output driven");
    pin_ce_a: assert property (!CE
        |=> $stable(TRIG_PIN)) else $error("trigger moved with clock off");
    irq_ce_a: assert property (!CE
        |=> $stable(IRQ)) else $error("interrupt moved with clock off");
    wait_ce_a: assert property (!CE
        |=> $stable(AVS_WAITREQUEST)) else $error("bus moved with clock off");
endmodule

bind la_trigger la_trigger_monitor #(.EDGE_N(EDGE_N), .LEVEL_N(LEVEL_N),
    .TOUT_MODE(TOUT_MODE)) mon (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .TRIG_BUS(TRIG_BUS), .TRIG_IN(TRIG_IN), .TRIG_PIN(TRIG_PIN),
    .TRIG_CHAIN(TRIG_CHAIN), .IRQ(IRQ), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

// ---- dv/la_trigger_bench.sv ----
// Self-checking testbench for the trigger front end.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("wrong value at %0t: %h not %h", $time, got, exp); \
        end \
    end
module la_trigger_bench import la_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [15:0] want = 16'h0;
    logic [15:0] bus;
    logic trig_in = 1'b1;
    logic trig_pin, trig_chain, irq, rd = 1'b0, wr = 1'b0, waitreq;
    logic [5:0] addr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] be = 4'hf;
    int errors = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    la_user_model #(.WIDTH(16)) user (.clk(clk), .rst_n(rst_n),
        .want(want), .bus(bus));
    la_trigger #(.EDGE_N(8), .LEVEL_N(8), .CNT_W(16), .MAG_EN(1),
        .TIN_MODE(LA_TIN_PIN),
        .TOUT_MODE(LA_TOUT_PIN)) DUT (.CLK(clk),
        .RST_N(rst_n), .CE(ce), .TRIG_BUS(bus), .TRIG_IN(trig_in),
        .TRIG_PIN(trig_pin), .TRIG_CHAIN(trig_chain), .IRQ(irq),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq));

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Holds the request until waitrequest is seen low at an edge.
    task automatic bus_op(input logic [5:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_op(a, 1'b1, d, q);
    endtask

    task automatic arm(input logic [15:0] v, input logic [31:0] ctrl);
        want <= v;
        wr_reg(LA_ADDR_CTRL, 32'h0);
        wr_reg(LA_ADDR_CTRL, ctrl | 32'h1);
    endtask

    task automatic t_reset();
        logic [5:0] a[7] = '{LA_ADDR_CTRL, LA_ADDR_CNT0, LA_ADDR_CNT1,
            LA_ADDR_PAT0, LA_ADDR_PAT1, LA_ADDR_INT_EN, 6'h3f};
        logic [31:0] e[7] = '{32'h0, 32'h1, 32'h1, LA_PAT_RST, LA_PAT_RST,
            32'h0, 32'h0};
        logic [31:0] q;
        `CHECK_EQ(trig_pin, 1'b1)
        `CHECK_EQ(trig_chain, 1'b0)
        `CHECK_EQ(irq, 1'b0)
        wr_reg(6'h3f, 32'hffff_ffff);
        for (int i = 0; i < 7; i++) begin
            bus_op(a[i], 1'b0, 32'h0, q);
            `CHECK_EQ(q, e[i])
        end
    endtask

    task automatic t_level();
        wr_reg(LA_ADDR_CNT0, 32'h3);
        wr_reg(LA_ADDR_PAT0 + 6'h1, 32'h2222_2221);
        arm(16'h0e00, 32'h4);
        want <= 16'hf1ff;
        cycles(2);
        want <= 16'h0e00;
        cycles(1);
        ce <= 1'b0;
        cycles(1);
        want <= 16'h0100;
        cycles(3);
        want <= 16'h0e00;
        cycles(2);
        ce <= 1'b1;
        cycles(5);
        `CHECK_EQ(trig_pin, 1'b0)
        want <= 16'h01a5;
        cycles(1);
        want <= 16'h0e00;
        cycles(5);
        `CHECK_EQ(trig_pin, 1'b1)
        cycles(5);
        `CHECK_EQ(trig_pin, 1'b1)
    endtask

    task automatic t_edge();
        logic [2:0] c[3] = '{LA_CODE_RISE, LA_CODE_FALL, LA_CODE_BOTH};
        logic s;
        wr_reg(LA_ADDR_CNT0, 32'h1);
        // A rise code on the first level line must act as don't-care.
        wr_reg(LA_ADDR_PAT0 + 6'h1, 32'h2222_2223);
        for (int i = 0; i < 3; i++) begin
            s = (c[i] != LA_CODE_FALL);
            wr_reg(LA_ADDR_PAT0, {28'h2222_222, 1'b0, c[i]});
            arm({15'h0, s}, 32'h4);
            cycles(3);
            `CHECK_EQ(trig_pin, 1'b0)
            want <= {15'h0, !s};
            cycles(4);
            `CHECK_EQ(trig_pin, c[i] == LA_CODE_BOTH)
            want <= {15'h0, s};
            cycles(4);
            `CHECK_EQ(trig_pin, 1'b1)
        end
    endtask

    task automatic t_compare();
        logic [15:0] hit[6] = '{16'h0100, 16'h0000, 16'h0200, 16'h0100,
            16'h00ff, 16'h0100};
        logic [15:0] miss[6] = '{16'h0101, 16'h0100, 16'h0100, 16'h00ff,
            16'h0100, 16'h0101};
        wr_reg(LA_ADDR_PAT0, 32'h0);
        wr_reg(LA_ADDR_PAT0 + 6'h1, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            arm(hit[i], 32'h4 | (i << LA_CTRL_CMP0));
            cycles(4);
            `CHECK_EQ(trig_pin, 1'b1)
            arm(miss[i], 32'h4 | (i << LA_CTRL_CMP0));
            cycles(4);
            `CHECK_EQ(trig_pin, 1'b0)
        end
    endtask

    task automatic t_tin_irq();
        logic [31:0] q;
        wr_reg(LA_ADDR_INT_EN, 32'h0);
        arm(16'h0, 32'h50);
        wr_reg(LA_ADDR_INT_CLR, 32'h7);
        cycles(2);
        `CHECK_EQ(trig_pin, 1'b1)
        `CHECK_EQ(irq, 1'b0)
        trig_in <= 1'b0;
        cycles(4);
        `CHECK_EQ(trig_pin, 1'b0)
        bus_op(LA_ADDR_STATUS, 1'b0, 32'h0, q);
        `CHECK_EQ(q[LA_ST_TIN], 1'b1)
        bus_op(LA_ADDR_INT_STAT, 1'b0, 32'h0, q);
        `CHECK_EQ(q[LA_ST_TRIG], 1'b1)
        `CHECK_EQ(irq, 1'b0)
        wr_reg(LA_ADDR_INT_EN, 32'h4);
        cycles(2);
        `CHECK_EQ(irq, 1'b1)
        wr_reg(LA_ADDR_INT_CLR, 32'h4);
        cycles(2);
        `CHECK_EQ(irq, 1'b0)
        trig_in <= 1'b1;
    endtask

    task automatic t_cond();
        wr_reg(LA_ADDR_PAT1, 32'h2222_2221);
        // Sequence mode ignores pattern zero hits before pattern one.
        arm(16'h0100, 32'h44);
        cycles(3);
        want <= 16'h0001;
        cycles(2);
        want <= 16'h0000;
        cycles(4);
        `CHECK_EQ(trig_pin, 1'b0)
        want <= 16'h0100;
        cycles(4);
        `CHECK_EQ(trig_pin, 1'b1)
        trig_in <= 1'b0;
        arm(16'h0001, 32'h1e);
        cycles(4);
        `CHECK_EQ(trig_pin, 1'b0)
        trig_in <= 1'b1;
        cycles(4);
        `CHECK_EQ(trig_pin, 1'b1)
    endtask

    task automatic tally_and_finish();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        errors++;
        tally_and_finish();
    end

    initial begin
        cycles(4);
        rst_n <= 1'b1;
        cycles(2);
        t_reset();
        t_level();
        t_edge();
        t_compare();
        t_tin_irq();
        t_cond();
        tally_and_finish();
    end
endmodule
